// ==== gpo_pkg.sv ====
// gpo_pkg: shared constants for the port pin block
// assumes: included before the port modules
package gpo_pkg;
  localparam int unsigned GPO_PINS     = 8;
  localparam logic        GPO_RST_BIT  = 1'b0;
  localparam logic [7:0]  GPO_RST_BYTE = 8'h00;
  // port d pin positions
  localparam int unsigned GPO_D_RX     = 0;
  localparam int unsigned GPO_D_TX     = 1;
  localparam int unsigned GPO_D_IRQ0   = 2;
  localparam int unsigned GPO_D_IRQ1   = 3;
  localparam int unsigned GPO_D_CMP1B  = 4;
  localparam int unsigned GPO_D_CMP1A  = 5;
  localparam int unsigned GPO_D_CAP    = 6;
  localparam int unsigned GPO_D_CMP2   = 7;
  // port b pin positions
  localparam int unsigned GPO_B_XCK    = 0;
  localparam int unsigned GPO_B_CNT1   = 1;
  localparam int unsigned GPO_B_IRQ2   = 2;
  localparam int unsigned GPO_B_CMP0   = 3;
  localparam int unsigned GPO_B_SEL    = 4;
  localparam int unsigned GPO_B_MOSI   = 5;
  localparam int unsigned GPO_B_MISO   = 6;
  localparam int unsigned GPO_B_SCK    = 7;
endpackage

// ==== gpo_sync.sv ====
// gpo_sync: latch then flop synchroniser for pin levels
// assumes: pins are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module gpo_sync
  import gpo_pkg::*;
#(
  parameter int unsigned W = GPO_PINS
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sample_q
);
  logic [W-1:0] latch_q;

  // [R05] latch open while clk high
  // holds what the pin showed as clk fell; kept as a falling-edge
  // register so the rising-edge capture below never races the latch
  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= '0;
    end else begin
      latch_q <= pin_in;
    end
  end

  // [R05] captured on next rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_q <= '0;
    end else begin
      sample_q <= latch_q;
    end
  end
endmodule
`default_nettype wire

// ==== gpo_pin_ctl.sv ====
// gpo_pin_ctl: per-pin pull-up, direction and value with overrides
// assumes: override vectors are driven on the same clock
`timescale 1ns/100ps
`default_nettype none
module gpo_pin_ctl
  import gpo_pkg::*;
#(
  parameter int unsigned W = GPO_PINS
) (
  input  wire logic         global_pullup_disable,
  input  wire logic [W-1:0] pin_dir_bit,
  input  wire logic [W-1:0] pin_out_bit,
  input  wire logic [W-1:0] pullup_override_en,
  input  wire logic [W-1:0] pullup_override_val,
  input  wire logic [W-1:0] dir_override_en,
  input  wire logic [W-1:0] dir_override_val,
  input  wire logic [W-1:0] value_override_en,
  input  wire logic [W-1:0] value_override_val,
  output logic      [W-1:0] pull_en,
  output logic      [W-1:0] drive_en,
  output logic      [W-1:0] drive_val
);
  logic [W-1:0] dir_eff;

  always_comb begin
    // [R14] overrides replace port controls
    dir_eff   = (dir_override_en & dir_override_val)
              | (~dir_override_en & pin_dir_bit);
    // [R02] direction selects drive
    drive_en  = dir_eff;
    drive_val = (value_override_en & value_override_val)
              | (~value_override_en & pin_out_bit);
    // [R01] pull-up only input, out bit 1
    pull_en   = (pullup_override_en & pullup_override_val)
              | (~pullup_override_en & ~dir_eff & pin_out_bit
                 & {W{~global_pullup_disable}});
  end
endmodule
`default_nettype wire

// ==== gpo_port.sv ====
// gpo_port: two 8-bit port pins groups with alternate functions
// assumes: pins resolved by the testbench from out and oe_n
// How it works
// [R01] pull-up: input, out bit 1, enabled; spi master pulls b7..b4 only while pull-ups are globally disabled
// [R02] dir 0 input, 1 drives out bit
// [R03] software passes hi-z or high between
// [R04] pin level readable whatever direction
// [R05] latch on high clock, then flop
// [R06] spi master forces pins input-less
// [R07] spi drives sck, mosi, miso values
// [R08] cmp0, irq2, usart clock, inputs routed
// [R09] timer1 compares on d5, d4
// [R10] usart tx forces d1 output
// [R11] usart rx forces d0 input
// [R12] d2, d3 feed external irqs
// [R13] d7, d5, d4 compare value overrides
// [R14] override enable selects override value
`timescale 1ns/100ps
`default_nettype none
module gpo_port
  import gpo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       global_pullup_disable,
  input  wire logic [7:0] pin_dir_bit_b,
  input  wire logic [7:0] pin_out_bit_b,
  input  wire logic [7:0] pin_dir_bit_d,
  input  wire logic [7:0] pin_out_bit_d,
  input  wire logic [7:0] pad_in_b,
  input  wire logic [7:0] pad_in_d,
  input  wire logic       serial_periph_enable,
  input  wire logic       master_select,
  input  wire logic       spi_sck_out,
  input  wire logic       spi_slave_out,
  input  wire logic       spi_master_out,
  input  wire logic       compare_zero_en,
  input  wire logic       compare_zero_out,
  input  wire logic       ext_irq_two_en,
  input  wire logic       usart_sync_select,
  input  wire logic       usart_ext_clock,
  input  wire logic       usart_tx_en,
  input  wire logic       usart_tx_data,
  input  wire logic       usart_rx_en,
  input  wire logic       compare_one_a_en,
  input  wire logic       compare_one_a_out,
  input  wire logic       compare_one_b_en,
  input  wire logic       compare_one_b_out,
  input  wire logic       compare_two_en,
  input  wire logic       compare_two_out,
  output logic      [7:0] pad_out_b,
  output logic      [7:0] pad_oe_n_b,
  output logic      [7:0] pad_pull_b,
  output logic      [7:0] pad_out_d,
  output logic      [7:0] pad_oe_n_d,
  output logic      [7:0] pad_pull_d,
  output logic      [7:0] pin_sample_bit_b,
  output logic      [7:0] pin_sample_bit_d,
  output logic            spi_sck_in_q,
  output logic            spi_master_in_q,
  output logic            spi_slave_in_q,
  output logic            spi_select_in_q,
  output logic            ext_irq_two_q,
  output logic            counter_one_ext_clk_q,
  output logic            counter_zero_ext_clk_q,
  output logic            usart_ext_clock_in_q,
  output logic            usart_rx_data_q,
  output logic            ext_irq_zero_q,
  output logic            ext_irq_one_q,
  output logic            capture_one_in_q,
  output logic            comparator_pos_in,
  output logic            comparator_neg_in
);
  // ****************************************************
  // synchronisers
  // ****************************************************
  logic [7:0] samp_b;
  logic [7:0] samp_d;

  // [R05] pin sampling synchroniser
  gpo_sync #(.W(8)) u_sync_b (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pad_in_b),
    .sample_q (samp_b)
  );

  gpo_sync #(.W(8)) u_sync_d (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pad_in_d),
    .sample_q (samp_d)
  );

  // ****************************************************
  // port b overrides
  // ****************************************************
  logic       spi_master;
  logic [7:0] b_pullup_override_en;
  logic [7:0] b_pullup_override_val;
  logic [7:0] b_dir_override_en;
  logic [7:0] b_value_override_en;
  logic [7:0] b_value_override_val;
  logic [7:0] b_input_enable_override_en;
  logic [7:0] b_input_enable_override_val;

  always_comb begin
    spi_master = serial_periph_enable & master_select;
    b_pullup_override_en  = '0;
    b_pullup_override_val  = '0;
    b_dir_override_en  = '0;
    b_value_override_en  = '0;
    b_value_override_val  = '0;
    b_input_enable_override_en = '0;
    b_input_enable_override_val = '0;
    // [R06] spi pull-up and direction override
    b_pullup_override_en[7:4] = {4{spi_master}};
    b_pullup_override_val[7:4] = pin_out_bit_b[7:4] & {4{global_pullup_disable}};
    b_dir_override_en[7:4] = {4{spi_master}};
    // [R07] spi value override, not select
    b_value_override_en[GPO_B_SCK]  = spi_master;
    b_value_override_en[GPO_B_MISO] = spi_master;
    b_value_override_en[GPO_B_MOSI] = spi_master;
    b_value_override_val[GPO_B_SCK]  = spi_sck_out;
    b_value_override_val[GPO_B_MISO] = spi_slave_out;
    b_value_override_val[GPO_B_MOSI] = spi_master_out;
    // [R08] compare zero and usart clock
    b_value_override_en[GPO_B_CMP0] = compare_zero_en;
    b_value_override_val[GPO_B_CMP0] = compare_zero_out;
    b_value_override_en[GPO_B_XCK]  = usart_sync_select;
    b_value_override_val[GPO_B_XCK]  = usart_ext_clock;
    // [R08] irq2 forces input enable
    b_input_enable_override_en[GPO_B_IRQ2] = ext_irq_two_en;
    b_input_enable_override_val[GPO_B_IRQ2] = 1'b1;
  end

  // ****************************************************
  // port d overrides
  // ****************************************************
  logic [7:0] d_pullup_override_en;
  logic [7:0] d_pullup_override_val;
  logic [7:0] d_dir_override_en;
  logic [7:0] d_dir_override_val;
  logic [7:0] d_value_override_en;
  logic [7:0] d_value_override_val;

  always_comb begin
    d_pullup_override_en = '0;
    d_pullup_override_val = '0;
    d_dir_override_en = '0;
    d_dir_override_val = '0;
    d_value_override_en = '0;
    d_value_override_val = '0;
    // [R10] transmitter forces output
    d_dir_override_en[GPO_D_TX] = usart_tx_en;
    d_dir_override_val[GPO_D_TX] = 1'b1;
    d_value_override_en[GPO_D_TX] = usart_tx_en;
    d_value_override_val[GPO_D_TX] = usart_tx_data;
    // [R11] receiver forces input, pull-up kept
    d_dir_override_en[GPO_D_RX] = usart_rx_en;
    d_dir_override_val[GPO_D_RX] = 1'b0;
    // [R09] [R13] compare value overrides
    d_value_override_en[GPO_D_CMP1A] = compare_one_a_en;
    d_value_override_val[GPO_D_CMP1A] = compare_one_a_out;
    d_value_override_en[GPO_D_CMP1B] = compare_one_b_en;
    d_value_override_val[GPO_D_CMP1B] = compare_one_b_out;
    d_value_override_en[GPO_D_CMP2]  = compare_two_en;
    d_value_override_val[GPO_D_CMP2]  = compare_two_out;
  end

  // ****************************************************
  // pin control
  // ****************************************************
  logic [7:0] b_pull;
  logic [7:0] b_drv;
  logic [7:0] b_val;
  logic [7:0] d_pull;
  logic [7:0] d_drv;
  logic [7:0] d_val;

  // [R14] per-pin override mux
  gpo_pin_ctl #(.W(8)) u_ctl_b (
    .global_pullup_disable (global_pullup_disable),
    .pin_dir_bit           (pin_dir_bit_b),
    .pin_out_bit           (pin_out_bit_b),
    .pullup_override_en    (b_pullup_override_en),
    .pullup_override_val   (b_pullup_override_val),
    .dir_override_en       (b_dir_override_en),
    .dir_override_val      (8'h00),
    .value_override_en     (b_value_override_en),
    .value_override_val    (b_value_override_val),
    .pull_en               (b_pull),
    .drive_en              (b_drv),
    .drive_val             (b_val)
  );

  gpo_pin_ctl #(.W(8)) u_ctl_d (
    .global_pullup_disable (global_pullup_disable),
    .pin_dir_bit           (pin_dir_bit_d),
    .pin_out_bit           (pin_out_bit_d),
    .pullup_override_en    (d_pullup_override_en),
    .pullup_override_val   (d_pullup_override_val),
    .dir_override_en       (d_dir_override_en),
    .dir_override_val      (d_dir_override_val),
    .value_override_en     (d_value_override_en),
    .value_override_val    (d_value_override_val),
    .pull_en               (d_pull),
    .drive_en              (d_drv),
    .drive_val             (d_val)
  );

  // ****************************************************
  // registered pad drive
  // ****************************************************
  // [R02] drive and enable per direction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pad_out_b  <= GPO_RST_BYTE;
      pad_oe_n_b <= 8'hff;
      pad_pull_b <= GPO_RST_BYTE;
      pad_out_d  <= GPO_RST_BYTE;
      pad_oe_n_d <= 8'hff;
      pad_pull_d <= GPO_RST_BYTE;
    end else begin
      pad_out_b  <= b_val;
      pad_oe_n_b <= ~b_drv;
      pad_pull_b <= b_pull;
      pad_out_d  <= d_val;
      pad_oe_n_d <= ~d_drv;
      pad_pull_d <= d_pull;
    end
  end

  // ****************************************************
  // digital input enable
  // ****************************************************
  logic [7:0] b_in_en;
  logic [7:0] b_in_lvl;

  // inputs stay enabled unless an override says otherwise
  always_comb begin
    b_in_en  = (b_input_enable_override_en & b_input_enable_override_val) | ~b_input_enable_override_en;
    b_in_lvl = samp_b & b_in_en;
  end

  // ****************************************************
  // input readback and routing
  // ****************************************************
  // [R04] samples visible in any direction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_sample_bit_b <= GPO_RST_BYTE;
      pin_sample_bit_d <= GPO_RST_BYTE;
    end else begin
      pin_sample_bit_b <= samp_b;
      pin_sample_bit_d <= samp_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spi_sck_in_q           <= GPO_RST_BIT;
      spi_master_in_q        <= GPO_RST_BIT;
      spi_slave_in_q         <= GPO_RST_BIT;
      spi_select_in_q        <= GPO_RST_BIT;
      ext_irq_two_q          <= GPO_RST_BIT;
      counter_one_ext_clk_q  <= GPO_RST_BIT;
      counter_zero_ext_clk_q <= GPO_RST_BIT;
      usart_ext_clock_in_q   <= GPO_RST_BIT;
      usart_rx_data_q        <= GPO_RST_BIT;
      ext_irq_zero_q         <= GPO_RST_BIT;
      ext_irq_one_q          <= GPO_RST_BIT;
      capture_one_in_q       <= GPO_RST_BIT;
    end else begin
      // [R07] spi inputs incl. select
      spi_sck_in_q           <= samp_b[GPO_B_SCK];
      spi_master_in_q        <= samp_b[GPO_B_MISO];
      spi_slave_in_q         <= samp_b[GPO_B_MOSI];
      spi_select_in_q        <= samp_b[GPO_B_SEL];
      // [R08] irq2, counter and usart clocks
      ext_irq_two_q          <= b_in_lvl[GPO_B_IRQ2];
      counter_one_ext_clk_q  <= samp_b[GPO_B_CNT1];
      counter_zero_ext_clk_q <= samp_b[GPO_B_XCK];
      usart_ext_clock_in_q   <= samp_b[GPO_B_XCK];
      usart_rx_data_q        <= samp_d[GPO_D_RX];
      // [R12] external irq sources
      ext_irq_zero_q         <= samp_d[GPO_D_IRQ0];
      ext_irq_one_q          <= samp_d[GPO_D_IRQ1];
      // [R13] capture input
      capture_one_in_q       <= samp_d[GPO_D_CAP];
    end
  end

  // [R08] analog comparator inputs, registered from synchroniser samples
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comparator_pos_in <= GPO_RST_BIT;
      comparator_neg_in <= GPO_RST_BIT;
    end else begin
      comparator_pos_in <= samp_b[GPO_B_IRQ2];
      comparator_neg_in <= samp_b[GPO_B_CMP0];
    end
  end
endmodule
`default_nettype wire

// ==== gpo_port_props.sv ====
// gpo_port_props: assertions on the port pin block
// assumes: bound to gpo_port, one clock domain
`timescale 1ns/100ps
`default_nettype none
module gpo_port_props (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       global_pullup_disable,
  input wire logic [7:0] pin_dir_bit_d,
  input wire logic [7:0] pin_out_bit_d,
  input wire logic [7:0] pin_out_bit_b,
  input wire logic [7:0] pad_in_d,
  input wire logic       serial_periph_enable,
  input wire logic       master_select,
  input wire logic       usart_tx_en,
  input wire logic       usart_tx_data,
  input wire logic       usart_rx_en,
  input wire logic       compare_one_a_en,
  input wire logic       compare_one_a_out,
  input wire logic [7:0] pad_out_d,
  input wire logic [7:0] pad_oe_n_d,
  input wire logic [7:0] pad_pull_d,
  input wire logic [7:0] pad_oe_n_b,
  input wire logic [7:0] pad_pull_b,
  input wire logic [7:0] pin_sample_bit_d,
  input wire logic [7:0] pin_sample_bit_b,
  input wire logic       spi_select_in_q,
  input wire logic       ext_irq_zero_q,
  input wire logic       capture_one_in_q
);
  logic [1:0] rel_q;
  // edges since reset release, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rel_q <= 2'h0;
    else if (rel_q != 2'h3) rel_q <= rel_q + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_pull;
    rel_q != 2'h0 |->
      pad_pull_d[3] == $past(~pin_dir_bit_d[3] & pin_out_bit_d[3]
                             & ~global_pullup_disable);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_drv;
    pin_dir_bit_d[3] |=> !pad_oe_n_d[3] && pad_out_d[3] == $past(pin_out_bit_d[3]);
  endproperty
  a_drv: assert property (p_drv) else $error("drive wrong");
  property p_spi;
    serial_periph_enable && master_select |=> pad_oe_n_b[7:4] == 4'hf &&
      pad_pull_b[7:4] == $past(pin_out_bit_b[7:4] & {4{global_pullup_disable}});
  endproperty
  a_spi: assert property (p_spi) else $error("spi override wrong");
  property p_tx;
    usart_tx_en |=> !pad_oe_n_d[1] && pad_out_d[1] == $past(usart_tx_data);
  endproperty
  a_tx: assert property (p_tx) else $error("tx pin not driven");
  property p_rx;
    usart_rx_en |=> pad_oe_n_d[0] &&
      pad_pull_d[0] == $past(pin_out_bit_d[0] & ~global_pullup_disable);
  endproperty
  a_rx: assert property (p_rx) else $error("rx pin wrong");
  property p_cmp;
    compare_one_a_en |=> pad_out_d[5] == $past(compare_one_a_out) &&
      pad_oe_n_d[5] == !$past(pin_dir_bit_d[5]);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare 1a wrong");
  property p_sync;
    rel_q == 2'h3 && pad_in_d == $past(pad_in_d) &&
      $past(pad_in_d) == $past(pad_in_d, 2) |-> pin_sample_bit_d == pad_in_d;
  endproperty
  a_sync: assert property (p_sync) else $error("sample wrong");
  property p_route;
    spi_select_in_q == pin_sample_bit_b[4] && ext_irq_zero_q ==
      pin_sample_bit_d[2] && capture_one_in_q == pin_sample_bit_d[6];
  endproperty
  a_route: assert property (p_route) else $error("routing wrong");
  c_tx: cover property (usart_tx_en ##1 !pad_oe_n_d[1]);
  c_spi: cover property (serial_periph_enable && master_select);
  c_smp: cover property (rel_q == 2'h3 && $fell(pin_sample_bit_d[6]));
endmodule
bind gpo_port gpo_port_props chk_u (.clk, .resetn, .global_pullup_disable,
  .pin_dir_bit_d, .pin_out_bit_d, .pin_out_bit_b, .pad_in_d,
  .serial_periph_enable, .master_select, .usart_tx_en, .usart_tx_data,
  .usart_rx_en, .compare_one_a_en, .compare_one_a_out, .pad_out_d,
  .pad_oe_n_d, .pad_pull_d, .pad_oe_n_b, .pad_pull_b, .pin_sample_bit_d,
  .pin_sample_bit_b, .spi_select_in_q, .ext_irq_zero_q, .capture_one_in_q);
`default_nettype wire

// ==== gpo_board.sv ====
// gpo_board: external circuitry on one 8-bit port
// assumes: oe_n low while the device drives a pad
`timescale 1ns/100ps
`default_nettype none
module gpo_board (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pull,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output wire logic [7:0] pad_in
);
  logic [7:0] flt_q = 8'h5a;
  // floating pads wander every cycle
  always @(posedge clk) flt_q <= ~flt_q;
  // device drive wins, else board, pull or float
  assign #3 pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
                   | (pad_oe_n & ~ext_en & (pad_pull | flt_q));
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for gpo_port
// assumes: gpo_board models both ports' pads
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk, resetn, global_pullup_disable, serial_periph_enable;
  logic       master_select, spi_sck_out, spi_slave_out, spi_master_out;
  logic       compare_zero_en, compare_zero_out, ext_irq_two_en;
  logic       usart_sync_select, usart_ext_clock, usart_tx_en;
  logic       usart_tx_data, usart_rx_en, compare_one_a_en;
  logic       compare_one_a_out, compare_one_b_en, compare_one_b_out;
  logic       compare_two_en, compare_two_out;
  logic [7:0] pin_dir_bit_b, pin_out_bit_b, pin_dir_bit_d, pin_out_bit_d;
  logic [7:0] ext_en_b, ext_val_b, ext_en_d, ext_val_d;
  wire  [7:0] pad_in_b, pad_in_d, pad_out_b, pad_oe_n_b, pad_pull_b;
  wire  [7:0] pad_out_d, pad_oe_n_d, pad_pull_d;
  wire  [7:0] pin_sample_bit_b, pin_sample_bit_d;
  wire        spi_sck_in_q, spi_master_in_q, spi_slave_in_q;
  wire        spi_select_in_q, ext_irq_two_q, counter_one_ext_clk_q;
  wire        counter_zero_ext_clk_q, usart_ext_clock_in_q;
  wire        usart_rx_data_q, ext_irq_zero_q, ext_irq_one_q;
  wire        capture_one_in_q, comparator_pos_in, comparator_neg_in;
  int         n_fail = 0;
  int         checks_done = 0;
  // rows: {pud, dir, out} then {pull, oe_n, sample}
  // order keeps 00 or 11 between pulled input and low
  logic [5:0] rows [8] = '{6'h02, 6'h0e, 6'h19, 6'h10,
                           6'h22, 6'h2a, 6'h39, 6'h30};
  gpo_port dut_u (.clk, .resetn, .global_pullup_disable, .pin_dir_bit_b,
    .pin_out_bit_b, .pin_dir_bit_d, .pin_out_bit_d, .pad_in_b, .pad_in_d,
    .serial_periph_enable, .master_select, .spi_sck_out, .spi_slave_out,
    .spi_master_out, .compare_zero_en, .compare_zero_out, .ext_irq_two_en,
    .usart_sync_select, .usart_ext_clock, .usart_tx_en, .usart_tx_data,
    .usart_rx_en, .compare_one_a_en, .compare_one_a_out, .compare_one_b_en,
    .compare_one_b_out, .compare_two_en, .compare_two_out, .pad_out_b,
    .pad_oe_n_b, .pad_pull_b, .pad_out_d, .pad_oe_n_d, .pad_pull_d,
    .pin_sample_bit_b, .pin_sample_bit_d, .spi_sck_in_q, .spi_master_in_q,
    .spi_slave_in_q, .spi_select_in_q, .ext_irq_two_q,
    .counter_one_ext_clk_q, .counter_zero_ext_clk_q, .usart_ext_clock_in_q,
    .usart_rx_data_q, .ext_irq_zero_q, .ext_irq_one_q, .capture_one_in_q,
    .comparator_pos_in, .comparator_neg_in);
  gpo_board brd_b (.clk, .pad_out(pad_out_b), .pad_oe_n(pad_oe_n_b),
    .pad_pull(pad_pull_b), .ext_en(ext_en_b), .ext_val(ext_val_b),
    .pad_in(pad_in_b));
  gpo_board brd_d (.clk, .pad_out(pad_out_d), .pad_oe_n(pad_oe_n_d),
    .pad_pull(pad_pull_d), .ext_en(ext_en_d), .ext_val(ext_val_d),
    .pad_in(pad_in_d));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 2000);
    n_fail++;
    summarize();
  end
  initial begin
    {resetn, global_pullup_disable, serial_periph_enable, master_select,
     spi_sck_out, spi_slave_out, spi_master_out, compare_zero_en,
     compare_zero_out, ext_irq_two_en, usart_sync_select, usart_ext_clock,
     usart_tx_en, usart_tx_data, usart_rx_en, compare_one_a_en,
     compare_one_a_out, compare_one_b_en, compare_one_b_out, compare_two_en,
     compare_two_out, pin_dir_bit_b, pin_out_bit_b, pin_dir_bit_d,
     pin_out_bit_d, ext_en_b, ext_val_b, ext_val_d} = '0;
    ext_en_d = 8'h09;
    repeat (6) @(posedge clk);
    chk(pad_oe_n_d, 8'hff);
    @(negedge clk) resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {global_pullup_disable, pin_dir_bit_d[3], pin_out_bit_d[3]} = rows[i][5:3];
      settle();
      chk({5'h00, pad_pull_d[3], pad_oe_n_d[3], pin_sample_bit_d[3]},
          {2'h0, rows[i]} & 8'h07);
    end
    {global_pullup_disable, usart_tx_en, usart_rx_en} = 3'h3;
    pin_dir_bit_d[1:0] = 2'h1;
    pin_out_bit_d[1:0] = 2'h1;
    settle();
    chk({2'h0, pad_oe_n_d[1:0], pad_out_d[1], pad_pull_d[0], usart_rx_data_q,
         pin_sample_bit_d[1]}, 8'h14);
    {serial_periph_enable, master_select, global_pullup_disable} = 3'h7;
    {spi_sck_out, spi_slave_out, spi_master_out} = 3'h5;
    {pin_dir_bit_b, pin_out_bit_b, ext_en_b, ext_val_b} = 32'hfff0_1010;
    settle();
    chk(pad_oe_n_b, 8'hf0);
    chk(pad_pull_b, 8'hf0);
    chk({1'h0, pad_out_b[7:5], spi_select_in_q, spi_sck_in_q, spi_master_in_q,
         spi_slave_in_q}, 8'h5f);
    master_select = 1'b0;
    settle();
    chk(pad_oe_n_b, 8'h00);
    {serial_periph_enable, global_pullup_disable, usart_tx_en} = 3'h0;
    {usart_rx_en, pin_out_bit_b, pin_dir_bit_d, pin_out_bit_d} = 25'h0b000;
    {compare_one_a_en, compare_one_a_out, compare_one_b_en} = 3'h7;
    {compare_two_en, compare_two_out, compare_zero_en} = 3'h7;
    {compare_zero_out, usart_sync_select, usart_ext_clock} = 3'h7;
    {ext_irq_two_en, ext_en_d, ext_val_d} = 17'h1_4d44;
    settle();
    chk(pad_out_d & 8'hb0, 8'ha0);
    chk(pad_oe_n_d & 8'hb0, 8'h00);
    chk({3'h0, pad_out_b[3], pad_out_b[0], ext_irq_zero_q, ext_irq_one_q,
         capture_one_in_q}, 8'h1d);
    chk({2'h0, ext_irq_two_q, counter_one_ext_clk_q, usart_ext_clock_in_q,
         counter_zero_ext_clk_q, comparator_pos_in, comparator_neg_in},
        8'h0d);
    pin_dir_bit_d = 8'h00;
    ext_val_d[6] = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, pin_sample_bit_d[6]}, 8'h01);
    chk(pad_oe_n_d & 8'hb0, 8'hb0);
    @(negedge clk);
    chk({7'h00, capture_one_in_q}, 8'h00);
    resetn = 1'b0;
    @(negedge clk);
    chk(pad_oe_n_b & pin_sample_bit_d, 8'h00);
    resetn = 1'b1;
    settle();
    summarize();
  end
endmodule
`default_nettype wire
